// File: bench/sees_bus_master.sv
`timescale 1ns/10ps
module sees_bus_master (
   // Clock
   input wire logic ref_clk_in,
   // Bus
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   task automatic tick();
      repeat (32) @(negedge ref_clk_in);
   endtask
   // Low phase spans two ticks so the slave's sync chain keeps up
   task automatic pulse(input logic pull, output logic got);
      scl_out = 1'b0;
      tick();
      sda_oe_out = pull;
      tick();
      scl_out = 1'b1;
      tick();
      got = sda_in;
      tick();
   endtask
   task automatic start();
      scl_out = 1'b0;
      tick();
      sda_oe_out = 1'b0;
      tick();
      scl_out = 1'b1;
      tick();
      sda_oe_out = 1'b1;
      tick();
   endtask
   task automatic stop();
      scl_out = 1'b0;
      tick();
      sda_oe_out = 1'b1;
      tick();
      scl_out = 1'b1;
      tick();
      sda_oe_out = 1'b0;
      tick();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         pulse(~d[i], s);
      end
      pulse(1'b0, s);
      ack = (s === 1'b0);
   endtask
   task automatic rbyte(input logic give_ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         pulse(1'b0, s);
         d[i] = s;
      end
      pulse(give_ack, s);
   endtask
endmodule

// File: bench/test_serial_eeprom_2wire_slave.sv
`timescale 1ns/10ps
module test_serial_eeprom_2wire_slave;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic [2:0] csel = 3'h0;
   logic scl, m_oe, sda_o, sda_oe, busy, a;
   wire logic sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
   logic [7:0] rb [0:15];
   int n_fail = 0;
   int n_checks = 0;
   localparam int TWC_SIM = 2000;
   int busy_cyc = 0;
   always @(negedge clk)
   begin
      if (busy === 1'b1)
         busy_cyc++;
   end
   initial
   begin
      forever #4 clk = ~clk;
   end
   initial
   begin
      #13;
      forever #40 lclk = ~lclk;
   end
   sees_slave #(.TWC_CYCLES(TWC_SIM)) uut (.ref_clk_in(clk), .link_clk_in(lclk),
      .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .wp_in(wp), .unused_chip_sel_0_in(csel[0]),
      .unused_chip_sel_1_in(csel[1]), .unused_chip_sel_2_in(csel[2]),
      .write_busy_out(busy));
   sees_bus_master m (.ref_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] cb(input logic [2:0] b, input logic r);
      return {sees_pkg::TYPE_CODE_DEF, b, r};
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [10:0] ad, input int n, input logic [7:0] base);
      m.start();
      m.wbyte(cb(ad[10:8], 1'b0), a);
      chk(a, 1'b1);
      m.wbyte(ad[7:0], a);
      chk(a, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         m.wbyte(base + 8'(i), a);
         chk(a, 1'b1);
      end
      m.stop();
   endtask
   // First poll lands inside the write cycle, later ones must get through
   task automatic poll_done();
      m.start();
      m.wbyte(cb(3'h0, 1'b0), a);
      m.stop();
      chk(a, 1'b0);
      for (int i = 0; i < 20 && !a; i++)
      begin
         m.start();
         m.wbyte(cb(3'h0, 1'b0), a);
         m.stop();
      end
      chk(a, 1'b1);
   endtask
   task automatic rd(input logic set, input logic [10:0] ad, input int n);
      if (set)
      begin
         m.start();
         m.wbyte(cb(ad[10:8], 1'b0), a);
         chk(a, 1'b1);
         m.wbyte(ad[7:0], a);
         chk(a, 1'b1);
      end
      m.start();
      m.wbyte(cb(ad[10:8], 1'b1), a);
      chk(a, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         m.rbyte(i < n - 1, rb[i]);
      end
      m.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_bad_code();
      m.start();
      m.wbyte({sees_pkg::TYPE_CODE_DEF + 4'h1, 4'h0}, a);
      m.stop();
      chk(a, 1'b0);
   endtask
   task automatic t_byte_write();
      wr(11'h000, 1, 8'ha5);
      repeat (10) @(negedge clk);
      chk(busy, 1'b1);
      poll_done();
   endtask
   // Seventeen bytes into one page: the first slot is overwritten
   // The page starts on a boundary, so only the in-page wrap is exercised
   task automatic t_page_write();
      wr(11'h7f0, 17, 8'h40);
      poll_done();
      rd(1'b1, 11'h7f0, 16);
      chk(rb[0], 8'h50);
      for (int j = 1; j < 16; j++)
      begin
         chk(rb[j], 8'h40 + 8'(j));
      end
   endtask
   task automatic t_wrap_read();
      rd(1'b1, 11'h7fe, 1);
      chk(rb[0], 8'h4e);
      rd(1'b0, 11'h000, 2);
      chk(rb[0], 8'h4f);
      chk(rb[1], 8'ha5);
   endtask
   task automatic t_protect();
      wp = 1'b1;
      csel = 3'h5;
      repeat (20) @(negedge clk);
      m.start();
      m.wbyte(cb(3'h0, 1'b0), a);
      m.wbyte(8'h00, a);
      m.wbyte(8'h33, a);
      m.stop();
      repeat (20) @(negedge clk);
      chk(busy, 1'b0);
      wp = 1'b0;
      repeat (20) @(negedge clk);
      rd(1'b1, 11'h000, 1);
      chk(rb[0], 8'ha5);
   endtask
   // Busy is counted edge by edge over the whole span, then the byte reads back
   task automatic t_busy_time();
      int guard;
      guard = 0;
      busy_cyc = 0;
      wr(11'h123, 1, 8'h3c);
      while ((busy === 1'b1 || busy_cyc == 0) && guard < 3000)
      begin
         @(negedge clk);
         guard++;
      end
      n_checks++;
      if (busy_cyc != TWC_SIM)
      begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, busy_cyc, TWC_SIM);
      end
      rd(1'b1, 11'h123, 1);
      chk(rb[0], 8'h3c);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      // Held over four link periods so both sync chains see it
      repeat (4) @(negedge lclk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (80) @(negedge clk);
      t_bad_code();
      t_byte_write();
      t_page_write();
      t_wrap_read();
      t_protect();
      t_busy_time();
      conclude();
   end
   initial
   begin
      repeat (95000) @(posedge clk);
      n_fail++;
      conclude();
   end
endmodule

// File: verilog/sees_pkg.sv
// Behaviour
// RULE_01 - Bus idle only when both lines high
// RULE_02 - SDA fall with SCL high is Start
// RULE_03 - SDA rise with SCL high is Stop
// RULE_04 - SDA changes only while SCL low
// RULE_05 - Acknowledge each received byte on ninth pulse
// RULE_06 - Ack holds SDA low through SCL high
// RULE_07 - No acknowledge while write cycle runs
// RULE_08 - Master nack ends read, SDA released
// RULE_09 - Acknowledge control byte only on type match
// RULE_10 - Block bits form top three address bits
// RULE_11 - Control byte LSB selects read or write
// RULE_12 - Word address byte loads the pointer
// RULE_13 - Stop after write data starts write cycle
// RULE_14 - Page write bumps low four pointer bits
// RULE_15 - Over sixteen bytes wrap, last sixteen kept
// RULE_16 - Master avoids page writes crossing boundaries
// RULE_17 - Write-protect high blocks all array writes
// RULE_18 - Ack polling answered once write cycle ends
// RULE_19 - Current read uses pointer, last plus one
// RULE_20 - Repeated Start aborts write, keeps pointer
// RULE_21 - Master ack fetches next sequential byte
// RULE_22 - SDA driven open-drain only
// RULE_23 - Legacy chip-select pins ignored entirely
// RULE_24 - Read pointer wraps from top to zero
// RULE_25 - Write cycle timed by parameterised timer
package sees_pkg;
   localparam int ADDR_W = 11;
   localparam int MEM_BYTES = 2048;
   localparam int PAGE_BYTES = 16;
   localparam logic [3:0] TYPE_CODE_DEF = 4'h5; // Arbitrary value
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] TX_LAST = 4'h7;
   localparam int REF_PERIOD_NS = 8;
   localparam int TWC_NS = 5000000;
   localparam int TWC_CYC = TWC_NS / REF_PERIOD_NS;
   localparam int TWC_W = 20;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_ACK = 3'h2,
      ST_TX = 3'h3,
      ST_MACK = 3'h4
   } sees_state_type;

   typedef enum logic [1:0] {
      BK_CTRL = 2'h0,
      BK_WADDR = 2'h1,
      BK_WDATA = 2'h2
   } sees_kind_type;

   typedef struct packed {
      logic [3:0] code;
      logic [2:0] blk;
      logic rd;
   } sees_ctrl_type;
endpackage

// File: verilog/sees_slave.sv
`timescale 1ns/10ps
module sees_slave #(
   parameter int TWC_CYCLES = sees_pkg::TWC_CYC,
   parameter logic [3:0] TYPE_CODE = sees_pkg::TYPE_CODE_DEF
) (
   // Clocks and reset
   input wire logic ref_clk_in,
   input wire logic link_clk_in,
   input wire logic rst_n_in,
   // Two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Straps
   input wire logic wp_in,
   input wire logic unused_chip_sel_0_in,
   input wire logic unused_chip_sel_1_in,
   input wire logic unused_chip_sel_2_in,
   // Status
   output logic write_busy_out
);

////////////////////////////////////////////////////////////////////////////////
   logic [1:0] rrst_ff;
   logic [1:0] lrst_ff;
   logic rst_n;
   logic lrst_n;

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rrst_ff <= 2'h0;
      else
         rrst_ff <= {rrst_ff[0], 1'b1};
   end

   always_ff @(posedge link_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lrst_ff <= 2'h0;
      else
         lrst_ff <= {lrst_ff[0], 1'b1};
   end

   assign rst_n = rrst_ff[1];
   assign lrst_n = lrst_ff[1];

////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; third stage only feeds edge detection
   logic scl_m_ff, scl_s_ff, scl_d_ff;
   logic sda_m_ff, sda_s_ff, sda_d_ff;
   logic wp_m_ff, wp_s_ff;
   logic ack_m_ff, ack_s_ff;
   logic ack_tog_ff;

   always_ff @(posedge link_clk_in or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
         {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
         // Protected until the strap is seen
         {wp_m_ff, wp_s_ff} <= 2'h3;
         {ack_m_ff, ack_s_ff} <= 2'h0;
      end
      else
      begin
         {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_in, scl_m_ff, scl_s_ff};
         {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
         {wp_m_ff, wp_s_ff} <= {wp_in, wp_m_ff};
         {ack_m_ff, ack_s_ff} <= {ack_tog_ff, ack_m_ff};
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s_ff & scl_d_ff;
   // Start only counts from a high data line with clock high [RULE_01] [RULE_02]
   assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
   assign stop_det = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff; // [RULE_03]

////////////////////////////////////////////////////////////////////////////////
   sees_pkg::sees_state_type st_ff;
   sees_pkg::sees_kind_type kind_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic rd_ff;
   logic [2:0] blk_ff;
   logic oe_ff;
   logic [10:0] ptr_ff;
   logic [7:0] pbuf_ff [sees_pkg::PAGE_BYTES];
   logic [15:0] pval_ff;
   logic [7:0] mem_ff [sees_pkg::MEM_BYTES];
   logic req_tog_ff;
   logic busy_l;
   logic byte_done;
   logic ctrl_ok;
   logic commit;
   logic [7:0] mem_q;
   sees_pkg::sees_ctrl_type ctrl;

   assign ctrl = sh_ff;
   assign busy_l = req_tog_ff ^ ack_s_ff;
   assign byte_done = (st_ff == sees_pkg::ST_RX) && scl_fall && (cnt_ff == sees_pkg::BIT_LAST);
   // Only the type code addresses the part; chip-select straps unread [RULE_23]
   assign ctrl_ok = (ctrl.code == TYPE_CODE) && !busy_l; // [RULE_07] [RULE_09] [RULE_18]
   assign mem_q = mem_ff[ptr_ff];
   assign commit = stop_det && (|pval_ff) && !wp_s_ff; // [RULE_13] [RULE_17]

   always_ff @(posedge link_clk_in or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         st_ff <= sees_pkg::ST_IDLE;
         kind_ff <= sees_pkg::BK_CTRL;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         rd_ff <= 1'b0;
         blk_ff <= 3'h0;
         oe_ff <= 1'b0;
      end
      else if (start_det)
      begin
         st_ff <= sees_pkg::ST_RX;
         kind_ff <= sees_pkg::BK_CTRL;
         cnt_ff <= 4'h0;
         oe_ff <= 1'b0;
      end
      else if (stop_det)
      begin
         st_ff <= sees_pkg::ST_IDLE;
         oe_ff <= 1'b0;
      end
      else
      begin
         case (st_ff)
            sees_pkg::ST_RX:
               if (scl_rise)
               begin
                  sh_ff <= {sh_ff[6:0], sda_s_ff};
                  cnt_ff <= cnt_ff + 4'h1;
               end
               else if (byte_done)
               begin
                  if (kind_ff == sees_pkg::BK_CTRL && !ctrl_ok)
                     st_ff <= sees_pkg::ST_IDLE;
                  else
                  begin
                     // Pull low from the eighth fall to the ninth [RULE_05] [RULE_06]
                     st_ff <= sees_pkg::ST_ACK;
                     oe_ff <= 1'b1;
                     if (kind_ff == sees_pkg::BK_CTRL)
                     begin
                        rd_ff <= ctrl.rd; // [RULE_11]
                        blk_ff <= ctrl.blk;
                     end
                  end
               end
            sees_pkg::ST_ACK:
               if (scl_fall)
               begin
                  cnt_ff <= 4'h0;
                  if (rd_ff)
                  begin
                     // Drive only after a detected fall, inside the low phase [RULE_04]
                     st_ff <= sees_pkg::ST_TX;
                     sh_ff <= mem_q;
                     oe_ff <= ~mem_q[7];
                  end
                  else
                  begin
                     st_ff <= sees_pkg::ST_RX;
                     oe_ff <= 1'b0;
                     if (kind_ff == sees_pkg::BK_CTRL)
                        kind_ff <= sees_pkg::BK_WADDR;
                     else
                        kind_ff <= sees_pkg::BK_WDATA;
                  end
               end
            sees_pkg::ST_TX:
               if (scl_fall)
               begin
                  if (cnt_ff == sees_pkg::TX_LAST)
                  begin
                     st_ff <= sees_pkg::ST_MACK;
                     oe_ff <= 1'b0;
                  end
                  else
                  begin
                     sh_ff <= {sh_ff[6:0], 1'b0};
                     oe_ff <= ~sh_ff[6]; // [RULE_22]
                     cnt_ff <= cnt_ff + 4'h1;
                  end
               end
            sees_pkg::ST_MACK:
               if (scl_rise)
               begin
                  // Nack leaves the line released for the Stop [RULE_08]
                  // Ack reuses the ack state with the line released [RULE_21]
                  if (sda_s_ff)
                     st_ff <= sees_pkg::ST_IDLE;
                  else
                     st_ff <= sees_pkg::ST_ACK;
               end
            default:
               st_ff <= sees_pkg::ST_IDLE;
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // A repeated Start never touches the pointer [RULE_20]
   always_ff @(posedge link_clk_in or negedge lrst_n)
   begin
      if (!lrst_n)
         ptr_ff <= 11'h000;
      else if (byte_done && kind_ff == sees_pkg::BK_WADDR)
         ptr_ff <= {blk_ff, sh_ff}; // [RULE_10] [RULE_12]
      else if (byte_done && kind_ff == sees_pkg::BK_WDATA)
         ptr_ff[3:0] <= ptr_ff[3:0] + 4'h1; // [RULE_14] [RULE_15] [RULE_16]
      else if (st_ff == sees_pkg::ST_ACK && scl_fall && rd_ff)
         ptr_ff <= ptr_ff + 11'h001; // [RULE_19] [RULE_21] [RULE_24]
   end

   // Page buffer indexed by the low pointer bits, so later bytes replace earlier
   always_ff @(posedge link_clk_in or negedge lrst_n)
   begin
      if (!lrst_n)
         pval_ff <= 16'h0000;
      else if (start_det || stop_det)
         pval_ff <= 16'h0000; // [RULE_20]
      else if (byte_done && kind_ff == sees_pkg::BK_WDATA)
         pval_ff[ptr_ff[3:0]] <= 1'b1; // [RULE_15]
   end

   always_ff @(posedge link_clk_in)
   begin
      if (byte_done && kind_ff == sees_pkg::BK_WDATA)
         pbuf_ff[ptr_ff[3:0]] <= sh_ff; // [RULE_14]
   end

   // Array commits at once; the timer only models the busy window
   always_ff @(posedge link_clk_in)
   begin
      if (commit)
         for (int i = 0; i < sees_pkg::PAGE_BYTES; i++)
            if (pval_ff[i])
               mem_ff[{ptr_ff[10:4], 4'(i)}] <= pbuf_ff[i]; // [RULE_13]
   end

   always_ff @(posedge link_clk_in or negedge lrst_n)
   begin
      if (!lrst_n)
         req_tog_ff <= 1'b0;
      else if (commit)
         req_tog_ff <= ~req_tog_ff;
   end

   always_ff @(posedge link_clk_in or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0; // [RULE_22]
         sda_oe_out <= oe_ff;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   logic req_m_ff, req_s_ff, req_seen_ff;
   logic [sees_pkg::TWC_W-1:0] twc_cnt_ff;

   always_ff @(posedge ref_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         {req_m_ff, req_s_ff} <= 2'h0;
      else
         {req_m_ff, req_s_ff} <= {req_tog_ff, req_m_ff};
   end

   always_ff @(posedge ref_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_busy_out <= 1'b0;
         twc_cnt_ff <= '0;
         req_seen_ff <= 1'b0;
         ack_tog_ff <= 1'b0;
      end
      else if (write_busy_out)
      begin
         if (twc_cnt_ff == sees_pkg::TWC_W'(TWC_CYCLES - 1))
         begin
            write_busy_out <= 1'b0; // [RULE_25]
            ack_tog_ff <= ~ack_tog_ff;
         end
         else
            twc_cnt_ff <= twc_cnt_ff + 1'b1;
      end
      else if (req_s_ff != req_seen_ff)
      begin
         write_busy_out <= 1'b1;
         twc_cnt_ff <= '0;
         req_seen_ff <= req_s_ff;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   start_rx_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_02]
      start_det |=> st_ff == sees_pkg::ST_RX && cnt_ff == 4'h0 && !oe_ff)
      else $error("start not taken");
   stop_idle_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_03]
      stop_det |=> st_ff == sees_pkg::ST_IDLE && !oe_ff)
      else $error("stop not taken");
   drive_low_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_04]
      $rose(oe_ff) |-> !scl_s_ff)
      else $error("sda driven while scl high");
   ack_hold_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_06]
      st_ff == sees_pkg::ST_ACK && oe_ff && scl_s_ff && !stop_det |=> oe_ff)
      else $error("ack released during scl high");
   busy_noack_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_07]
      byte_done && kind_ff == sees_pkg::BK_CTRL && busy_l |=> !oe_ff[*2])
      else $error("ack while busy");
   type_match_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_09]
      byte_done && kind_ff == sees_pkg::BK_CTRL && ctrl.code != TYPE_CODE
      |=> st_ff == sees_pkg::ST_IDLE && !oe_ff)
      else $error("foreign control byte acked");
   nack_free_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_08]
      st_ff == sees_pkg::ST_MACK && scl_rise && sda_s_ff && !stop_det && !start_det
      |=> st_ff == sees_pkg::ST_IDLE && !oe_ff)
      else $error("line held after nack");
   page_fix_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_14]
      byte_done && kind_ff == sees_pkg::BK_WDATA
      |=> ptr_ff[10:4] == $past(ptr_ff[10:4]) && ptr_ff[3:0] == $past(ptr_ff[3:0]) + 4'h1)
      else $error("page pointer wrong");
   wp_block_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_17]
      stop_det && wp_s_ff |=> $stable(req_tog_ff))
      else $error("write under protect");
   busy_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n) // [RULE_25]
      $rose(write_busy_out) |-> write_busy_out[*8])
      else $error("write cycle too short");
   ack_data_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_05]
      byte_done && kind_ff != sees_pkg::BK_CTRL |=> st_ff == sees_pkg::ST_ACK && oe_ff)
      else $error("data byte not acked");
   poll_free_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_18]
      byte_done && kind_ff == sees_pkg::BK_CTRL && ctrl.code == TYPE_CODE && !busy_l
      |=> st_ff == sees_pkg::ST_ACK && oe_ff)
      else $error("free part refused its code");
   read_sel_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_11]
      st_ff == sees_pkg::ST_ACK && scl_fall && rd_ff |=> st_ff == sees_pkg::ST_TX)
      else $error("read not started");
   // The 11-bit sum rolls the top address over to zero
   read_step_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // [RULE_21]
      st_ff == sees_pkg::ST_ACK && scl_fall && rd_ff
      |=> ptr_ff == $past(ptr_ff) + 11'h001)
      else $error("read pointer not advanced");

   read_nack_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_ff == sees_pkg::ST_MACK && scl_rise && sda_s_ff);
   seq_read_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
      st_ff == sees_pkg::ST_MACK && scl_rise && !sda_s_ff);
   commit_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n) commit);
   page_wrap_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
      byte_done && kind_ff == sees_pkg::BK_WDATA && ptr_ff[3:0] == 4'hf);
   poll_refused_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
      byte_done && kind_ff == sees_pkg::BK_CTRL && busy_l);
endmodule
